// file: verilog/acsb_defines.svh
// Register offsets, field positions, reset values and counts of the sequence buffer control.
`ifndef ACSB_DEFINES_SVH
`define ACSB_DEFINES_SVH
// ----------------------------------------
// Register offsets (word index on the plain port)
// ----------------------------------------
`define ACSB_OFF_CTRL2      4'h0
`define ACSB_OFF_STATUS     4'h1
`define ACSB_OFF_MASK       4'h2
`define ACSB_OFF_STATE      4'h3
`define ACSB_OFF_BUFDATA    4'h4
// ----------------------------------------
// Control register two field positions
// ----------------------------------------
`define ACSB_POS_ALT        0
`define ACSB_POS_FILLMODE   1
`define ACSB_POS_NSAMP_LO   2
`define ACSB_POS_NSAMP_HI   6
`define ACSB_POS_FILLSTAT   7
`define ACSB_POS_SCAN       10
`define ACSB_POS_PLACE      11
`define ACSB_POS_CAL        12
`define ACSB_POS_NEGREF     13
`define ACSB_POS_POSREF_LO  14
`define ACSB_POS_POSREF_HI  15
// Writable bits: all but 9..8 and the hardware-owned fill-status bit 7.
`define ACSB_CTRL2_WMASK    16'hFC7F
`define ACSB_CTRL2_RESET    16'h0000
// ----------------------------------------
// Status and mask bits
// ----------------------------------------
`define ACSB_IRQ_CONV       0
`define ACSB_IRQ_HALF       1
`define ACSB_IRQ_OVF        2
`define ACSB_IRQ_RESET      3'h0
`define ACSB_BUF_DEPTH      16
`endif

// file: verilog/acsb_pkg.sv
// Types shared by the sequence buffer control.
`default_nettype none
package acsb_pkg;
   // Which input-select set the multiplexer uses.
   typedef enum logic [1:0] {
      ACSB_SET_A = 2'b01,
      ACSB_SET_B = 2'b10
   } acsb_set_t;
endpackage : acsb_pkg
`default_nettype wire

// file: verilog/acsb_result_mem.sv
// Result buffer memory with registered read data.
`default_nettype none
module acsb_result_mem #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   input  wire logic                     clk,
   input  wire logic                     wrEn,
   input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
   input  wire logic [WIDTH-1:0]         wrData,
   input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
   output logic      [WIDTH-1:0]         rdData
);
   // Storage array, no reset needed for data.
   logic [WIDTH-1:0] mem [DEPTH];

   // Write port.
   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // Registered read port.
   always_ff @(posedge clk) begin
      rdData <= mem[rdAddr];
   end
endmodule : acsb_result_mem
`default_nettype wire

// file: verilog/acsb_seq_ctrl.sv
// Sequence and result buffer control of the successive-approximation converter.
//
// Notes on behaviour
// - Alternate set on: A, then B, alternating.
// - Alternate set off: always use set A.
// - Fill mode and status only when placement off.
// - Fill status meaningful only in split mode.
`include "acsb_defines.svh"
`default_nettype none
module acsb_seq_ctrl #(
   parameter int DATA_W = 12,
   parameter int DEPTH  = `ACSB_BUF_DEPTH
) (
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   // Register port.
   input  wire logic [3:0]        regAddr,
   input  wire logic [15:0]       regWdata,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic      [15:0]       regRdata,
   // Converter side.
   input  wire logic              sampleStart,
   input  wire logic              convDone,
   input  wire logic [DATA_W-1:0] convResult,
   input  wire logic [3:0]        convChannel,
   output logic      [1:0]        inputSetSel,
   output logic                   irq
);
   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   // The read index, channel number and register map all assume sixteen words.
   if (DEPTH != 16 || DATA_W < 1 || DATA_W > 16) begin : g_bad_params
      $error("Unsupported depth or width.");
   end

   localparam int AW = $clog2(DEPTH);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [15:0]       ctrl2;         // Control register two, software part.
   logic              fillStatus;    // Which half is being filled.
   logic [2:0]        irqStatus;     // Sticky event bits.
   logic [2:0]        irqMask;       // Interrupt enables.
   logic              useSetB;       // Next sample takes set B.
   logic [4:0]        sampleCount;   // Conversions since the last interrupt.
   logic [AW-1:0]     wrPtr;         // Next write location in the buffer.
   logic [AW-1:0]     rdIndex;       // Location selected for reading.
   logic [DATA_W-1:0] memRdData;     // Registered buffer read data.
   logic              convEvent;     // Interrupt point reached.

   // Field decodes.
   wire logic       altSel        = ctrl2[`ACSB_POS_ALT];
   wire logic       placeEn       = ctrl2[`ACSB_POS_PLACE];
   wire logic [4:0] samplesPerIrq = ctrl2[`ACSB_POS_NSAMP_HI:`ACSB_POS_NSAMP_LO];
   // Split mode holds only while placement is off.
   wire logic       splitMode     = ctrl2[`ACSB_POS_FILLMODE] & ~placeEn;
   wire logic       regWrCtrl     = regWr && (regAddr == `ACSB_OFF_CTRL2);

   assign convEvent = convDone && (sampleCount == samplesPerIrq);

   // ----------------------------------------
   // Software-writable control register
   // ----------------------------------------
   // Only writable bits are stored; fill status is owned by hardware.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl2 <= `ACSB_CTRL2_RESET;
      end else if (regWrCtrl) begin
         ctrl2 <= regWdata & `ACSB_CTRL2_WMASK;
      end
   end

   // ----------------------------------------
   // Input-select sequencing
   // ----------------------------------------
   // Each sample start advances the set when alternation is on.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         useSetB <= 1'b0;
      end else if (regWrCtrl) begin
         useSetB <= 1'b0; // Restart the sequence on set A.
      end else if (sampleStart) begin
         if (altSel) begin
            useSetB <= ~useSetB;
         end else begin
            useSetB <= 1'b0;
         end
      end
   end

   // Drive the select set for the sample in progress.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         inputSetSel <= acsb_pkg::ACSB_SET_A;
      end else if (sampleStart) begin
         if (altSel && useSetB) begin
            inputSetSel <= acsb_pkg::ACSB_SET_B;
         end else begin
            inputSetSel <= acsb_pkg::ACSB_SET_A;
         end
      end
   end

   // ----------------------------------------
   // Sample counting and fill-status
   // ----------------------------------------
   // Counts conversions up to the programmed interrupt point.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sampleCount <= 5'h00;
      end else if (regWrCtrl) begin
         sampleCount <= 5'h00;
      end else if (convDone) begin
         sampleCount <= convEvent ? 5'h00 : 5'(sampleCount + 5'h01);
      end
   end

   // Fill status toggles at each interrupt in split mode only.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         fillStatus <= 1'b0;
      end else if (!splitMode) begin
         fillStatus <= 1'b0;
      end else if (convEvent) begin
         fillStatus <= ~fillStatus;
      end
   end

   // Write pointer: placement by channel, or FIFO from start or half.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr <= '0;
      end else if (regWrCtrl) begin
         wrPtr <= '0;
      end else if (convDone) begin
         if (convEvent) begin
            // Split mode starts the next group in the other half.
            wrPtr <= (splitMode && !fillStatus) ? AW'(DEPTH / 2) : '0;
         end else begin
            wrPtr <= AW'(wrPtr + 1'b1);
         end
      end
   end

   wire logic [AW-1:0] memWrAddr = placeEn ? AW'(convChannel) : wrPtr;
   // A new read index is passed straight to the memory, so a data read right
   // after the index write already sees the newly selected word.
   wire logic [AW-1:0] memRdAddr = (regWr && regAddr == `ACSB_OFF_STATE) ? regWdata[AW-1:0] : rdIndex;

   acsb_result_mem #(
      .WIDTH (DATA_W),
      .DEPTH (DEPTH)
   ) acsb_result_mem_i (
      .clk    (core_clk),
      .wrEn   (convDone),
      .wrAddr (memWrAddr),
      .wrData (convResult),
      .rdAddr (memRdAddr),
      .rdData (memRdData)
   );

   // ----------------------------------------
   // Interrupt status and mask
   // ----------------------------------------
   // Sticky events; a new event wins over a write-one clear.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         irqStatus <= `ACSB_IRQ_RESET;
      end else begin
         irqStatus <= (irqStatus & ~((regWr && regAddr == `ACSB_OFF_STATUS) ? regWdata[2:0] : 3'h0))
                      | {convDone && !convEvent && wrPtr == AW'(DEPTH - 1) && !placeEn,
                         convEvent && splitMode,
                         convEvent};
      end
   end

   // Mask register.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         irqMask <= `ACSB_IRQ_RESET;
      end else if (regWr && regAddr == `ACSB_OFF_MASK) begin
         irqMask <= regWdata[2:0];
      end
   end

   // Level interrupt output from a flip-flop.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStatus & irqMask);
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   // Buffer index register selects the word read at the data offset.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdIndex <= '0;
      end else if (regWr && regAddr == `ACSB_OFF_STATE) begin
         rdIndex <= regWdata[AW-1:0];
      end
   end

   // Capture register reads straight into the output flop at the read strobe.
   // The value stands from the cycle after the strobe until the next read.
   // Unmapped offsets read zero.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdata <= 16'h0000;
      end else if (regRd) begin
         unique case (regAddr)
            `ACSB_OFF_CTRL2:   regRdata <= ctrl2 | (16'(fillStatus) << `ACSB_POS_FILLSTAT);
            `ACSB_OFF_STATUS:  regRdata <= {13'h0000, irqStatus};
            `ACSB_OFF_MASK:    regRdata <= {13'h0000, irqMask};
            `ACSB_OFF_STATE:   regRdata <= {8'h00, sampleCount, useSetB, 2'h0} | (16'(rdIndex) << 8);
            `ACSB_OFF_BUFDATA: regRdata <= 16'(memRdData); // Word at the read index.
            default:           regRdata <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   // A sample start that is due to use set A while alternation is on.
   sequence s_startA;
      sampleStart && altSel && !useSetB && !regWrCtrl;
   endsequence

   // A sample start that is due to use set B while alternation is on.
   sequence s_startB;
      sampleStart && altSel && useSetB && !regWrCtrl;
   endsequence

   // A sample on set A drives set A and lines up set B for the next one.
   property p_alt_b;
      @(posedge core_clk) disable iff (!arst_n)
      s_startA |=> (inputSetSel == acsb_pkg::ACSB_SET_A) && useSetB;
   endproperty
   a_alt_b: assert property (p_alt_b) else $error("First sample did not use set A.");

   // A sample on set B drives set B and returns to set A for the next one.
   property p_alt_next;
      @(posedge core_clk) disable iff (!arst_n)
      s_startB |=> (inputSetSel == acsb_pkg::ACSB_SET_B) && !useSetB;
   endproperty
   a_alt_next: assert property (p_alt_next) else $error("Second sample did not use set B.");

   property p_only_a;
      @(posedge core_clk) disable iff (!arst_n)
      (sampleStart && !altSel) |=> inputSetSel == acsb_pkg::ACSB_SET_A;
   endproperty
   a_only_a: assert property (p_only_a) else $error("Set B used with alternation off.");

   property p_place_no_split;
      @(posedge core_clk) disable iff (!arst_n)
      placeEn |=> !fillStatus;
   endproperty
   a_place_no_split: assert property (p_place_no_split) else $error("Fill status active with placement on.");

   property p_status_unused;
      @(posedge core_clk) disable iff (!arst_n)
      !ctrl2[`ACSB_POS_FILLMODE] |=> !fillStatus;
   endproperty
   a_status_unused: assert property (p_status_unused) else $error("Fill status set outside split mode.");

   property p_toggle;
      @(posedge core_clk) disable iff (!arst_n)
      (convEvent && splitMode && !regWrCtrl) |=> fillStatus != $past(fillStatus);
   endproperty
   a_toggle: assert property (p_toggle) else $error("Fill status did not toggle at interrupt.");

   property p_hold;
      @(posedge core_clk) disable iff (!arst_n)
      (!convEvent && splitMode && !regWrCtrl) |=> $stable(fillStatus);
   endproperty
   a_hold: assert property (p_hold) else $error("Fill status changed without interrupt.");

   property p_irq;
      @(posedge core_clk) disable iff (!arst_n)
      (convEvent && irqMask[`ACSB_IRQ_CONV] && !regWr) |-> ##2 irq;
   endproperty
   a_irq: assert property (p_irq) else $error("Interrupt did not follow event.");

   property p_reset_seq;
      @(posedge core_clk) disable iff (!arst_n)
      regWrCtrl |=> !useSetB && sampleCount == 5'h00;
   endproperty
   a_reset_seq: assert property (p_reset_seq) else $error("Write did not restart sequence.");
endmodule : acsb_seq_ctrl
`default_nettype wire

// file: verif/acsb_adc_model.sv
// Behavioural model of the converter (sample start, conversion delay, result and channel) facing the sequence control.
`default_nettype none
module acsb_adc_model (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        go,
   output logic             sampleStart,
   output logic             convDone,
   output logic [11:0]      convResult,
   output logic [3:0]       convChannel
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0]  cnt;   // Cycles left until the conversion ends.
   logic [11:0] data;  // Next result to hand over.
   // A request starts a sample; the result follows a few cycles later as a pulse.
   // Outside the done pulse the result lines flip to their inverse every cycle, so stale data is never trusted.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sampleStart <= 1'b0;
         convDone    <= 1'b0;
         convResult  <= 12'h000;
         convChannel <= 4'h0;
         cnt         <= 3'h0;
         data        <= 12'h101;
      end else begin
         sampleStart <= go;
         convDone    <= (cnt == 3'h1);
         if (go) begin
            cnt <= 3'h4;
         end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
         end
         if (cnt == 3'h1) begin
            convResult  <= data;
            convChannel <= data[3:0];
            data        <= data + 12'h011;
         end else begin
            convResult  <= ~convResult;
            convChannel <= ~convChannel;
         end
      end
   end
endmodule : acsb_adc_model
`default_nettype wire

// file: verif/adc_sequence_buffer_control_tb.sv
// Self-checking testbench of the converter sequence and buffer control.
`include "acsb_defines.svh"
`default_nettype none
module adc_sequence_buffer_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        arst_n   = 1'b0;
   logic [3:0]  regAddr  = 4'h0;
   logic [15:0] regWdata = 16'h0000;
   logic        regWr    = 1'b0;
   logic        regRd    = 1'b0;
   logic [15:0] regRdata;
   logic        go       = 1'b0;
   logic        sampleStart, convDone;
   logic [11:0] convResult;
   logic [3:0]  convChannel;
   logic [1:0]  inputSetSel;
   logic        irq;
   int          failCount = 0;  // Mismatches seen.
   int          nChecks   = 0;  // Comparisons made.
   logic [15:0] rd;
   logic [15:0] rows [4][2] = '{'{16'hFFFF, 16'hFC7F}, '{16'h0380, 16'h0000},
                               '{16'h5A5A, 16'h585A}, '{16'h0000, 16'h0000}};
   always #10 core_clk = ~core_clk;
   acsb_seq_ctrl acsb_seq_ctrl_i (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .sampleStart(sampleStart), .convDone(convDone), .convResult(convResult),
      .convChannel(convChannel), .inputSetSel(inputSetSel), .irq(irq));
   acsb_adc_model acsb_adc_model_i (.core_clk(core_clk), .arst_n(arst_n), .go(go),
      .sampleStart(sampleStart), .convDone(convDone), .convResult(convResult),
      .convChannel(convChannel));
   // ----------------------------------------
   // Bus and comparison tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      nChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWr    <= 1'b0;
   endtask : wr
   // The read data stand from the cycle after the strobe, so it is sampled there.
   task automatic rdReg(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd   <= 1'b0;
      #1;
      d = regRdata;
   endtask : rdReg
   // One sample and conversion; returns once irq has had time to follow the status.
   task automatic conv();
      int k;
      @(posedge core_clk);
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      k = 0;
      while (convDone !== 1'b1 && k < 20) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      check("conv done", {15'h0, convDone}, 16'h0001);
      repeat (2) @(posedge core_clk);
      #1;
   endtask : conv
   task automatic endOfTest();
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : endOfTest
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (7) @(posedge core_clk);
      #1;
      check("reset irq", {15'h0, irq}, 16'h0000);
      check("reset set", {14'h0, inputSetSel}, 16'h0001);
      @(posedge core_clk);
      arst_n <= 1'b1;
      $display("test reset done");
      // Ordinary control writes: reserved and fill-status bits must not stick.
      for (int i = 0; i < 4; i++) begin
         wr(`ACSB_OFF_CTRL2, rows[i][0]);
         rdReg(`ACSB_OFF_CTRL2, rd);
         check("ctrl2 row", rd, rows[i][1]);
      end
      rdReg(4'hF, rd);
      check("unmapped", rd, 16'h0000);
      $display("test registers done");
      // Alternation on: A, B, A, B.
      wr(`ACSB_OFF_CTRL2, 16'h0001);
      for (int i = 0; i < 4; i++) begin
         conv();
         check("alt set", {14'h0, inputSetSel}, (i % 2) ? 16'h0002 : 16'h0001);
      end
      // Alternation off: always A.
      wr(`ACSB_OFF_CTRL2, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         conv();
         check("fixed set", {14'h0, inputSetSel}, 16'h0001);
      end
      $display("test alternation done");
      // Split mode, two conversions per interrupt point.
      wr(`ACSB_OFF_STATUS, 16'h0007);
      wr(`ACSB_OFF_CTRL2, 16'h0006);
      wr(`ACSB_OFF_MASK, 16'h0001);
      conv();
      check("irq early", {15'h0, irq}, 16'h0000);
      conv();
      rdReg(`ACSB_OFF_CTRL2, rd);
      check("fill upper", rd, 16'h0086);
      rdReg(`ACSB_OFF_STATUS, rd);
      check("status", rd, 16'h0003);
      check("irq set", {15'h0, irq}, 16'h0001);
      wr(`ACSB_OFF_STATUS, 16'h0003);
      repeat (2) @(posedge core_clk);
      #1;
      check("irq clear", {15'h0, irq}, 16'h0000);
      conv();
      conv();
      rdReg(`ACSB_OFF_CTRL2, rd);
      check("fill lower", rd, 16'h0006);
      check("irq again", {15'h0, irq}, 16'h0001);
      // Results are numbered from 0x101 in steps of 0x011; the eighth and ninth
      // conversions of the run went to the lower half, the next two to the upper.
      wr(`ACSB_OFF_STATE, 16'h0008);
      rdReg(`ACSB_OFF_BUFDATA, rd);
      check("upper half word", rd, 16'h019A);
      wr(`ACSB_OFF_STATE, 16'h0001);
      rdReg(`ACSB_OFF_BUFDATA, rd);
      check("lower half word", rd, 16'h0189);
      wr(`ACSB_OFF_MASK, 16'h0000);
      repeat (2) @(posedge core_clk);
      #1;
      check("irq masked", {15'h0, irq}, 16'h0000);
      $display("test split buffer done");
      // Placement on, or FIFO mode: the fill status must stay at zero.
      wr(`ACSB_OFF_CTRL2, 16'h0806);
      conv();
      conv();
      rdReg(`ACSB_OFF_CTRL2, rd);
      check("placement", rd, 16'h0806);
      // The twelfth result, 0x1BC, names channel 12 and lands in that word.
      wr(`ACSB_OFF_STATE, 16'h000C);
      rdReg(`ACSB_OFF_BUFDATA, rd);
      check("channel word", rd, 16'h01BC);
      wr(`ACSB_OFF_CTRL2, 16'h0004);
      conv();
      conv();
      rdReg(`ACSB_OFF_CTRL2, rd);
      check("fifo mode", rd, 16'h0004);
      $display("test fill status gating done");
      // Reset in mid-run: set B lined up and a read index set, then both cleared.
      wr(`ACSB_OFF_CTRL2, 16'h0001);
      conv();
      rdReg(`ACSB_OFF_STATE, rd);
      check("state before reset", rd, 16'h0C04);
      @(posedge core_clk);
      arst_n <= 1'b0;
      @(posedge core_clk);
      arst_n <= 1'b1;
      #1;
      check("reset again set", {14'h0, inputSetSel}, 16'h0001);
      rdReg(`ACSB_OFF_STATE, rd);
      check("state after reset", rd, 16'h0000);
      rdReg(`ACSB_OFF_CTRL2, rd);
      check("ctrl2 after reset", rd, 16'h0000);
      $display("test mid-run reset done");
      endOfTest();
   end
   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (5000) @(posedge core_clk);
      failCount++;
      endOfTest();
   end
endmodule : adc_sequence_buffer_control_tb
`default_nettype wire
